// ### inc/ipc_pkg.sv
// Shared constants and types of the interrupt priority controller
package ipc_pkg;
  // Register addresses
  localparam logic [31:0] IPC_ADDR_PRIO_B = 32'hfffffe60;
  localparam logic [31:0] IPC_ADDR_VEC_A = 32'hfffffe62;
  localparam logic [31:0] IPC_ADDR_VEC_B = 32'hfffffe64;
  localparam logic [31:0] IPC_ADDR_VEC_C = 32'hfffffe66;
  localparam logic [31:0] IPC_ADDR_VEC_D = 32'hfffffe68;
  localparam logic [31:0] IPC_ADDR_CTRL = 32'hfffffee0;
  localparam logic [31:0] IPC_ADDR_PRIO_A = 32'hfffffee2;
  localparam logic [31:0] IPC_ADDR_VEC_WDG = 32'hfffffee4;
  localparam logic [31:0] IPC_ADDR_VEC_DIV = 32'hffffff0c;
  localparam logic [31:0] IPC_ADDR_VEC_TC0 = 32'hffffffa0;
  localparam logic [31:0] IPC_ADDR_VEC_TC1 = 32'hffffffa8;
  // Reset values
  localparam logic [15:0] IPC_RST_16 = 16'h0000;
  localparam logic [31:0] IPC_RST_32 = 32'h0000_0000;
  // Control register field positions
  localparam int IPC_CTRL_PIN_BIT = 15;
  localparam int IPC_CTRL_EDGE_BIT = 8;
  localparam int IPC_CTRL_VMODE_BIT = 0;
  // Levels and vectors
  localparam logic [4:0] IPC_LVL_NMI = 5'h10;
  localparam logic [4:0] IPC_LVL_BRK = 5'h0f;
  localparam logic [3:0] IPC_MASK_TOP = 4'hf;
  localparam logic [3:0] IPC_LVL_OFF = 4'h0;
  localparam logic [3:0] IPC_IRL_NONE = 4'hf;
  localparam logic [7:0] IPC_VEC_NMI = 8'h0b;
  localparam logic [7:0] IPC_VEC_BRK = 8'h0c;
  localparam logic [7:0] IPC_AUTOVEC_BASE = 8'h40;
  localparam logic [3:0] IPC_CS_IDLE = 4'hf;
  // Least length of the vector fetch cycle, covering the pin synchroniser
  localparam logic [1:0] IPC_FETCH_MIN = 2'h2;
  // Number of peripheral request lines
  localparam int IPC_N_PER = 12;
  // Winning source kinds
  typedef enum logic [1:0] {
    IPC_SRC_NMI = 2'b00,
    IPC_SRC_BRK = 2'b01,
    IPC_SRC_IRL = 2'b10,
    IPC_SRC_PER = 2'b11
  } ipc_src_t;
  // Acceptance sequencer states
  typedef enum logic {
    IPC_ST_IDLE = 1'b0,
    IPC_ST_FETCH = 1'b1
  } ipc_state_t;
endpackage

// ### logic/ipc_priority_arbiter.sv
// Interrupt priority arbiter with register port and vector fetch cycle
`timescale 1ns/1ps
module ipc_priority_arbiter (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  input wire logic nmi_pin,
  input wire logic break_req,
  input wire logic [3:0] level_request_pins_n,
  input wire logic [11:0] periph_req,
  input wire logic [3:0] mask_level_field,
  input wire logic [31:0] vector_base,
  input wire logic cpu_ack,
  output logic irq_req_q,
  output logic [4:0] irq_req_level_q,
  output logic [1:0] irq_source_q,
  output logic [3:0] irq_per_index_q,
  output logic irq_take_q,
  output logic [3:0] irq_new_mask_q,
  output logic [7:0] irq_vector_q,
  output logic [31:0] irq_vector_addr_q,
  output logic vector_fetch_strobe_n_q,
  output logic [3:0] accepted_level_outputs_q,
  input wire logic [7:0] vector_input_pins,
  input wire logic wait_n,
  input wire logic [3:0] cs_n_in,
  output logic [3:0] chip_selects_n_q
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0] prio_a_q, prio_b_q; // Peripheral priorities
  logic [15:0] vec_a_q, vec_b_q, vec_c_q, vec_d_q, vec_wdg_q; // Vectors
  logic [31:0] vec_div_q, vec_tc0_q, vec_tc1_q; // Wide vector registers
  logic edge_sel_q, vmode_q; // Control bits
  logic nmi_m_q, nmi_s_q, nmi_p_q; // Nonmaskable pin sync and history
  logic [3:0] irl_m_q, irl_s_q; // Level pins sync
  logic wait_m_q, wait_s_q; // Wait pin sync
  logic [7:0] dat_m_q, dat_s_q; // Vector pins sync
  logic nmi_pend_q; // Latched nonmaskable event
  ipc_pkg::ipc_state_t st_q, st_d; // Sequencer state
  logic [1:0] fcnt_q; // Fetch cycle length counter
  logic [3:0] per_lvl [ipc_pkg::IPC_N_PER]; // Level per source
  logic [6:0] per_vec [ipc_pkg::IPC_N_PER]; // Vector per source
  logic [ipc_pkg::IPC_N_PER-1:0] per_ok; // Source eligible
  logic per_any;
  logic [3:0] per_best_lvl, per_best_idx;
  logic [6:0] per_best_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  // Decode hits
  wire hit_pb = reg_addr == ipc_pkg::IPC_ADDR_PRIO_B;
  wire hit_va = reg_addr == ipc_pkg::IPC_ADDR_VEC_A;
  wire hit_vb = reg_addr == ipc_pkg::IPC_ADDR_VEC_B;
  wire hit_vc = reg_addr == ipc_pkg::IPC_ADDR_VEC_C;
  wire hit_vd = reg_addr == ipc_pkg::IPC_ADDR_VEC_D;
  wire hit_ct = reg_addr == ipc_pkg::IPC_ADDR_CTRL;
  wire hit_pa = reg_addr == ipc_pkg::IPC_ADDR_PRIO_A;
  wire hit_vw = reg_addr == ipc_pkg::IPC_ADDR_VEC_WDG;
  wire hit_vv = reg_addr == ipc_pkg::IPC_ADDR_VEC_DIV;
  wire hit_v0 = reg_addr == ipc_pkg::IPC_ADDR_VEC_TC0;
  wire hit_v1 = reg_addr == ipc_pkg::IPC_ADDR_VEC_TC1;

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Control register view, bit 15 is the live pin level
  wire [15:0] ctrl_view = {nmi_s_q, 6'h00, edge_sel_q, 7'h00, vmode_q};

  // Read data selection, unmapped reads give zero
  wire [31:0] rd_w =
    hit_pb ? {16'h0000, prio_b_q} :
    hit_va ? {16'h0000, vec_a_q} :
    hit_vb ? {16'h0000, vec_b_q} :
    hit_vc ? {16'h0000, vec_c_q} :
    hit_vd ? {16'h0000, vec_d_q} :
    hit_ct ? {16'h0000, ctrl_view} :
    hit_pa ? {16'h0000, prio_a_q} :
    hit_vw ? {16'h0000, vec_wdg_q} :
    hit_vv ? vec_div_q :
    hit_v0 ? vec_tc0_q :
    hit_v1 ? vec_tc1_q : 32'h0000_0000;

  // Register writes and read data, small registers take byte lanes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prio_a_q <= ipc_pkg::IPC_RST_16;
      prio_b_q <= ipc_pkg::IPC_RST_16;
      vec_a_q <= ipc_pkg::IPC_RST_16;
      vec_b_q <= ipc_pkg::IPC_RST_16;
      vec_c_q <= ipc_pkg::IPC_RST_16;
      vec_d_q <= ipc_pkg::IPC_RST_16;
      vec_wdg_q <= ipc_pkg::IPC_RST_16;
      vec_div_q <= ipc_pkg::IPC_RST_32;
      vec_tc0_q <= ipc_pkg::IPC_RST_32;
      vec_tc1_q <= ipc_pkg::IPC_RST_32;
      edge_sel_q <= 1'b0;
      vmode_q <= 1'b0;
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      if (reg_wr && hit_pa) prio_a_q <= merge16(prio_a_q, reg_wdata, reg_be);
      if (reg_wr && hit_pb) prio_b_q <= merge16(prio_b_q, reg_wdata, reg_be);
      if (reg_wr && hit_va) vec_a_q <= merge16(vec_a_q, reg_wdata, reg_be);
      if (reg_wr && hit_vb) vec_b_q <= merge16(vec_b_q, reg_wdata, reg_be);
      if (reg_wr && hit_vc) vec_c_q <= merge16(vec_c_q, reg_wdata, reg_be);
      if (reg_wr && hit_vd) vec_d_q <= merge16(vec_d_q, reg_wdata, reg_be);
      if (reg_wr && hit_vw) vec_wdg_q <= merge16(vec_wdg_q, reg_wdata, reg_be);
      if (reg_wr && hit_vv) vec_div_q <= reg_wdata;
      if (reg_wr && hit_v0) vec_tc0_q <= reg_wdata;
      if (reg_wr && hit_v1) vec_tc1_q <= reg_wdata;
      // Control bits sit in both lanes
      if (reg_wr && hit_ct && reg_be[1])
        edge_sel_q <= reg_wdata[ipc_pkg::IPC_CTRL_EDGE_BIT];
      if (reg_wr && hit_ct && reg_be[0])
        vmode_q <= reg_wdata[ipc_pkg::IPC_CTRL_VMODE_BIT];
      reg_rdata_q <= reg_rd ? rd_w : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Two flops per outside input, a third for edge history
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      nmi_m_q <= 1'b0;
      nmi_s_q <= 1'b0;
      nmi_p_q <= 1'b0;
      irl_m_q <= ipc_pkg::IPC_IRL_NONE;
      irl_s_q <= ipc_pkg::IPC_IRL_NONE;
      wait_m_q <= 1'b1;
      wait_s_q <= 1'b1;
      dat_m_q <= 8'h00;
      dat_s_q <= 8'h00;
    end else begin
      nmi_m_q <= nmi_pin;
      nmi_s_q <= nmi_m_q;
      nmi_p_q <= nmi_s_q;
      irl_m_q <= level_request_pins_n;
      irl_s_q <= irl_m_q;
      wait_m_q <= wait_n;
      wait_s_q <= wait_m_q;
      dat_m_q <= vector_input_pins;
      dat_s_q <= dat_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source evaluation
  // Selected edge of the nonmaskable pin
  wire nmi_edge = edge_sel_q ? (nmi_s_q && !nmi_p_q)
                             : (!nmi_s_q && nmi_p_q);
  // Level pins: pattern 0000 is 15, 1111 is none
  wire [3:0] irl_lvl = ipc_pkg::IPC_MASK_TOP - irl_s_q;
  wire irl_valid = irl_s_q != ipc_pkg::IPC_IRL_NONE;
  wire irl_ok = irl_valid && (irl_lvl > mask_level_field);
  wire brk_ok = break_req
                && (ipc_pkg::IPC_MASK_TOP > mask_level_field);

  // Flat level and vector maps in fixed default order, index 0 first
  wire [47:0] lvl_flat = {prio_a_q[15:12], prio_a_q[11:8], prio_a_q[11:8],
                          prio_a_q[7:4], prio_a_q[7:4], prio_b_q[15:12],
                          prio_b_q[15:12], prio_b_q[15:12], prio_b_q[15:12],
                          prio_b_q[11:8], prio_b_q[11:8], prio_b_q[11:8]};
  wire [83:0] vec_flat = {vec_div_q[6:0], vec_tc0_q[6:0], vec_tc1_q[6:0],
                          vec_wdg_q[14:8], vec_wdg_q[6:0], vec_a_q[14:8],
                          vec_a_q[6:0], vec_b_q[14:8], vec_b_q[6:0],
                          vec_c_q[14:8], vec_c_q[6:0], vec_d_q[14:8]};

  // Per source level, vector and eligibility
  for (genvar gi = 0; gi < ipc_pkg::IPC_N_PER; gi++) begin : g_per
    localparam int HI = ipc_pkg::IPC_N_PER - 1 - gi;
    assign per_lvl[gi] = lvl_flat[HI*4 +: 4];
    assign per_vec[gi] = vec_flat[HI*7 +: 7];
    assign per_ok[gi] = periph_req[gi]
                        && per_lvl[gi] != ipc_pkg::IPC_LVL_OFF
                        && per_lvl[gi] > mask_level_field;
  end

  // Highest peripheral, earlier index wins a tie
  always_comb begin
    per_any = 1'b0;
    per_best_lvl = 4'h0;
    per_best_idx = 4'h0;
    per_best_vec = 7'h00;
    for (int i = 0; i < ipc_pkg::IPC_N_PER; i++) begin
      if (per_ok[i] && (!per_any || per_lvl[i] > per_best_lvl)) begin
        per_any = 1'b1;
        per_best_lvl = per_lvl[i];
        per_best_idx = 4'(i);
        per_best_vec = per_vec[i];
      end
    end
  end

  // Overall winner: nonmaskable, break, then the higher of pins and peripherals, pins on a tie
  wire irl_wins = irl_ok && (!per_any || irl_lvl >= per_best_lvl);
  wire win_valid = nmi_pend_q || brk_ok || irl_ok || per_any;
  wire [1:0] win_src = nmi_pend_q ? ipc_pkg::IPC_SRC_NMI :
                       brk_ok ? ipc_pkg::IPC_SRC_BRK :
                       irl_wins ? ipc_pkg::IPC_SRC_IRL :
                       ipc_pkg::IPC_SRC_PER;
  wire [4:0] win_lvl = nmi_pend_q ? ipc_pkg::IPC_LVL_NMI :
                       brk_ok ? ipc_pkg::IPC_LVL_BRK :
                       irl_wins ? {1'b0, irl_lvl} : {1'b0, per_best_lvl};
  wire [7:0] auto_vec = ipc_pkg::IPC_AUTOVEC_BASE
                        | {5'h00, irl_lvl[3:1]};
  wire [7:0] win_vec = nmi_pend_q ? ipc_pkg::IPC_VEC_NMI :
                       brk_ok ? ipc_pkg::IPC_VEC_BRK :
                       irl_wins ? auto_vec : {1'b0, per_best_vec};

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance sequencer
  wire acc_w = st_q == ipc_pkg::IPC_ST_IDLE && irq_req_q && cpu_ack;
  wire to_fetch = acc_w && irq_source_q == ipc_pkg::IPC_SRC_IRL
                  && vmode_q;
  wire fetch_done = st_q == ipc_pkg::IPC_ST_FETCH
                    && fcnt_q >= ipc_pkg::IPC_FETCH_MIN && wait_s_q;
  wire take_w = (acc_w && !to_fetch) || fetch_done;
  wire [7:0] ext_vec = {1'b0, dat_s_q[6:0]};
  wire [7:0] take_vec = fetch_done ? ext_vec : irq_vector_q;
  wire [3:0] take_mask = (irq_source_q == ipc_pkg::IPC_SRC_NMI
                          || irq_source_q == ipc_pkg::IPC_SRC_BRK)
                         ? ipc_pkg::IPC_MASK_TOP
                         : irq_req_level_q[3:0];
  wire [31:0] take_addr = vector_base + {22'h000000, take_vec, 2'b00};
  // Set wins over the clear on acceptance
  wire nmi_clr = acc_w && irq_source_q == ipc_pkg::IPC_SRC_NMI;

  // Next state
  always_comb begin
    case (st_q)
      ipc_pkg::IPC_ST_IDLE: st_d = to_fetch ? ipc_pkg::IPC_ST_FETCH
                                            : ipc_pkg::IPC_ST_IDLE;
      ipc_pkg::IPC_ST_FETCH: st_d = fetch_done ? ipc_pkg::IPC_ST_IDLE
                                               : ipc_pkg::IPC_ST_FETCH;
      default: st_d = ipc_pkg::IPC_ST_IDLE;
    endcase
  end

  // Request presentation and acceptance outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_q <= ipc_pkg::IPC_ST_IDLE;
      fcnt_q <= 2'h0;
      nmi_pend_q <= 1'b0;
      irq_req_q <= 1'b0;
      irq_req_level_q <= 5'h00;
      irq_source_q <= ipc_pkg::IPC_SRC_NMI;
      irq_per_index_q <= 4'h0;
      irq_vector_q <= 8'h00;
      irq_take_q <= 1'b0;
      irq_new_mask_q <= 4'h0;
      irq_vector_addr_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      nmi_pend_q <= nmi_edge || (nmi_pend_q && !nmi_clr);
      // Fetch length counter, saturating
      if (st_q != ipc_pkg::IPC_ST_FETCH) fcnt_q <= 2'h0;
      else if (fcnt_q < ipc_pkg::IPC_FETCH_MIN) fcnt_q <= fcnt_q + 2'h1;
      // Winner is refreshed only while idle and not being taken
      irq_req_q <= win_valid && st_d == ipc_pkg::IPC_ST_IDLE && !take_w
                   && !acc_w;
      if (st_q == ipc_pkg::IPC_ST_IDLE && !acc_w) begin
        irq_req_level_q <= win_lvl;
        irq_source_q <= win_src;
        irq_per_index_q <= per_best_idx;
        irq_vector_q <= win_vec;
      end else if (fetch_done) begin
        irq_vector_q <= ext_vec;
      end
      irq_take_q <= take_w;
      if (take_w) begin
        irq_new_mask_q <= take_mask;
        irq_vector_addr_q <= take_addr;
      end
    end
  end

  // Fetch cycle pins follow the next state so they open with the cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vector_fetch_strobe_n_q <= 1'b1;
      accepted_level_outputs_q <= 4'h0;
      chip_selects_n_q <= ipc_pkg::IPC_CS_IDLE;
    end else begin
      vector_fetch_strobe_n_q <= st_d != ipc_pkg::IPC_ST_FETCH;
      if (to_fetch) accepted_level_outputs_q <= irq_req_level_q[3:0];
      chip_selects_n_q <= st_d == ipc_pkg::IPC_ST_FETCH
                          ? ipc_pkg::IPC_CS_IDLE : cs_n_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  level_zero_masked_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq_take_q && $past(irq_source_q) == ipc_pkg::IPC_SRC_PER
    |-> irq_new_mask_q != 4'h0) else $error("level 0 source taken");
  nmi_request_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    nmi_pend_q && st_q == ipc_pkg::IPC_ST_IDLE && !acc_w
    |=> irq_req_q && irq_req_level_q == 5'h10)
    else $error("nonmaskable not requested");
  nmi_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    edge_sel_q && $rose(nmi_s_q) && $stable(edge_sel_q) |=> nmi_pend_q)
    else $error("rising edge missed");
  nmi_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    acc_w && irq_source_q == ipc_pkg::IPC_SRC_NMI
    |=> irq_take_q && irq_new_mask_q == 4'hf)
    else $error("nonmaskable mask not 15");
  irl_none_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irl_s_q == 4'hf |-> !irl_ok) else $error("1111 seen as request");
  auto_vector_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq_take_q && $past(irq_source_q) == ipc_pkg::IPC_SRC_IRL
    && !$past(vmode_q) |-> irq_vector_q == 8'h40 + 8'(irq_new_mask_q >> 1))
    else $error("auto vector wrong");
  fetch_strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    to_fetch |=> !vector_fetch_strobe_n_q
    && accepted_level_outputs_q == $past(irq_req_level_q[3:0])
    ##1 !vector_fetch_strobe_n_q) else $error("fetch strobe wrong");
  fetch_cs_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !vector_fetch_strobe_n_q |-> chip_selects_n_q == 4'hf)
    else $error("chip select low in fetch");
  fetch_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q == ipc_pkg::IPC_ST_FETCH && !wait_s_q |=> !irq_take_q)
    else $error("fetch ended under wait");
  above_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq_req_q && irq_req_level_q != 5'h10
    |-> irq_req_level_q > {1'b0, $past(mask_level_field)})
    else $error("request not above mask");
  vector_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq_take_q |-> irq_vector_addr_q
    == $past(vector_base) + {22'h000000, irq_vector_q, 2'b00})
    else $error("table address wrong");
  nmi_take_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
    acc_w && irq_source_q == ipc_pkg::IPC_SRC_NMI);
  ext_fetch_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
    fetch_done);
  per_take_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
    acc_w && irq_source_q == ipc_pkg::IPC_SRC_PER);
  brk_take_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
    acc_w && irq_source_q == ipc_pkg::IPC_SRC_BRK);
endmodule // ipc_priority_arbiter

// ### testbench/ipc_partner_model.sv
// Core and external vector source facing the arbiter
`timescale 1ns/1ps
module ipc_partner_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic irq_req_q,
  input wire logic vector_fetch_strobe_n_q,
  input wire logic [7:0] ext_vec,
  input wire logic stall,
  output logic cpu_ack,
  output logic [7:0] vector_input_pins,
  output logic wait_n
);
  logic [1:0] wcnt_q; // Fetch cycles already stretched
  ////////////////////////////////////////////////////////////////////////
  // Core acks a standing request for one cycle, then acks again a cycle later if it still stands
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !irq_req_q || cpu_ack) begin
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Wait held low for the first fetch cycles when stalling
  always_ff @(posedge clk_sys) begin
    if (!rst_b || vector_fetch_strobe_n_q) begin
      wcnt_q <= 2'h0;
    end else if (wcnt_q != 2'h3) begin
      wcnt_q <= wcnt_q + 2'h1;
    end
  end
  assign wait_n = !(stall && !vector_fetch_strobe_n_q && wcnt_q != 2'h3);
  // Vector driven only during the strobe, else its inverse
  assign vector_input_pins = vector_fetch_strobe_n_q ? ~ext_vec : ext_vec;
endmodule // ipc_partner_model

// ### testbench/interrupt_priority_controller_tb_top.sv
// Self-checking bench of the interrupt priority arbiter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module interrupt_priority_controller_tb_top;
  logic clk_sys, rst_b, reg_wr, reg_rd, nmi_pin, break_req, cpu_ack;
  logic [31:0] reg_addr, reg_wdata, reg_rdata_q, vector_base;
  logic [31:0] irq_vector_addr_q;
  logic [1:0] reg_be, irq_source_q;
  logic [3:0] level_request_pins_n, mask_level_field, irq_per_index_q;
  logic [3:0] irq_new_mask_q, accepted_level_outputs_q, cs_n_in;
  logic [3:0] chip_selects_n_q;
  logic [11:0] periph_req;
  logic [4:0] irq_req_level_q;
  logic [7:0] irq_vector_q, vector_input_pins, ext_vec;
  logic irq_req_q, irq_take_q, vector_fetch_strobe_n_q, wait_n, stall;
  logic cs_bad; // Chip select seen low during fetch
  logic [3:0] lvl; // Expected level
  logic [7:0] vec; // Expected vector
  int mismatches = 0;
  int n_compared = 0;
  int nlow; // Strobe low cycles of last acceptance
  ipc_priority_arbiter dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .nmi_pin(nmi_pin), .break_req(break_req),
    .level_request_pins_n(level_request_pins_n), .periph_req(periph_req),
    .mask_level_field(mask_level_field), .vector_base(vector_base),
    .cpu_ack(cpu_ack), .irq_req_q(irq_req_q),
    .irq_req_level_q(irq_req_level_q), .irq_source_q(irq_source_q),
    .irq_per_index_q(irq_per_index_q), .irq_take_q(irq_take_q),
    .irq_new_mask_q(irq_new_mask_q), .irq_vector_q(irq_vector_q),
    .irq_vector_addr_q(irq_vector_addr_q),
    .vector_fetch_strobe_n_q(vector_fetch_strobe_n_q),
    .accepted_level_outputs_q(accepted_level_outputs_q),
    .vector_input_pins(vector_input_pins), .wait_n(wait_n),
    .cs_n_in(cs_n_in), .chip_selects_n_q(chip_selects_n_q));
  ipc_partner_model partner_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .irq_req_q(irq_req_q), .vector_fetch_strobe_n_q(vector_fetch_strobe_n_q),
    .ext_vec(ext_vec), .stall(stall), .cpu_ack(cpu_ack),
    .vector_input_pins(vector_input_pins), .wait_n(wait_n));
  ////////////////////////////////////////////////////////////////////////
  // Clock at 4 ns
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Bus cycle helpers
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] be);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_be <= be;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // Read data stand in this cycle; taken at its closing edge
    @(posedge clk_sys);
    `CHK("rdata", e, reg_rdata_q)
  endtask
  // Waits for acceptance, watching the fetch cycle on the way
  task automatic wait_take;
    nlow = 0;
    cs_bad = 1'b0;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_sys);
      // Outputs are seen as they stood through the cycle just ended
      if (irq_take_q === 1'b1) break;
      if (vector_fetch_strobe_n_q === 1'b0) begin
        nlow++;
        if (chip_selects_n_q !== 4'hf) cs_bad = 1'b1;
      end
    end
    `CHK("take", 1'b1, irq_take_q)
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset values, lanes and unmapped place
  task automatic t_regs;
    rd(ipc_pkg::IPC_ADDR_CTRL, 32'h8000);
    rd(ipc_pkg::IPC_ADDR_VEC_DIV, 32'h0);
    rd(32'hfffffe70, 32'h0);
    wr(ipc_pkg::IPC_ADDR_VEC_A, 32'hffff, 2'b10);
    rd(ipc_pkg::IPC_ADDR_VEC_A, 32'hff00);
  endtask
  // Every pin pattern in auto vector mode, then masking
  task automatic t_pins_auto;
    for (int p = 0; p < 15; p++) begin
      level_request_pins_n <= p[3:0];
      lvl = 4'hf - p[3:0];
      vec = 8'h40 + {5'h0, lvl[3:1]};
      wait_take;
      `CHK("src", 2'h2, irq_source_q)
      `CHK("mask", lvl, irq_new_mask_q)
      `CHK("vec", vec, irq_vector_q)
      `CHK("addr", vector_base + {vec, 2'h0}, irq_vector_addr_q)
      level_request_pins_n <= 4'hf;
      idle(8);
      `CHK("none", 1'b0, irq_req_q)
    end
    mask_level_field <= 4'h3;
    level_request_pins_n <= 4'hc;
    idle(10);
    `CHK("masked", 1'b0, irq_req_q)
    level_request_pins_n <= 4'hf;
    mask_level_field <= 4'h0;
    idle(4);
  endtask
  // External vector mode, prompt and stretched
  task automatic t_pins_ext;
    wr(ipc_pkg::IPC_ADDR_CTRL, 32'h1, 2'b01);
    for (int s = 0; s < 2; s++) begin
      stall <= s[0];
      ext_vec <= s[0] ? 8'h7a : 8'h35;
      level_request_pins_n <= 4'h5;
      wait_take;
      `CHK("lvl_out", 4'ha, accepted_level_outputs_q)
      `CHK("strobe", s[0], nlow > 3)
      `CHK("cs", 1'b0, cs_bad)
      `CHK("cs_out", 4'h5, chip_selects_n_q)
      `CHK("ext", s[0] ? 8'h7a : 8'h35, irq_vector_q)
      `CHK("mask", 4'ha, irq_new_mask_q)
      level_request_pins_n <= 4'hf;
      // Room for the repeat fetch that the still synced pins cause
      idle(12);
    end
    wr(ipc_pkg::IPC_ADDR_CTRL, 32'h0, 2'b01);
  endtask
  // Nonmaskable on falling then rising edge, break request
  task automatic t_nmi_brk;
    mask_level_field <= 4'hf;
    nmi_pin <= 1'b0;
    wait_take;
    `CHK("lvl", 5'h10, irq_req_level_q)
    `CHK("mask", 4'hf, irq_new_mask_q)
    `CHK("vec", 8'h0b, irq_vector_q)
    wr(ipc_pkg::IPC_ADDR_CTRL, 32'h100, 2'b10);
    rd(ipc_pkg::IPC_ADDR_CTRL, 32'h100);
    nmi_pin <= 1'b1;
    wait_take;
    `CHK("src", 2'h0, irq_source_q)
    mask_level_field <= 4'he;
    break_req <= 1'b1;
    wait_take;
    break_req <= 1'b0;
    `CHK("bsrc", 2'h1, irq_source_q)
    `CHK("bmask", 4'hf, irq_new_mask_q)
    `CHK("bvec", 8'h0c, irq_vector_q)
    idle(8);
  endtask
  // Peripheral levels, vectors, masking and tie order
  task automatic t_periph;
    mask_level_field <= 4'h0;
    periph_req <= 12'h800;
    idle(10);
    `CHK("off", 1'b0, irq_req_q)
    periph_req <= 12'h0;
    wr(ipc_pkg::IPC_ADDR_PRIO_A, 32'h5000, 2'b11);
    wr(ipc_pkg::IPC_ADDR_PRIO_B, 32'h0500, 2'b11);
    wr(ipc_pkg::IPC_ADDR_VEC_DIV, 32'h22, 2'b00);
    wr(ipc_pkg::IPC_ADDR_VEC_D, 32'h3300, 2'b11);
    periph_req <= 12'h801;
    wait_take;
    periph_req <= 12'h800;
    `CHK("idx", 4'h0, irq_per_index_q)
    `CHK("pvec", 8'h22, irq_vector_q)
    `CHK("pmask", 4'h5, irq_new_mask_q)
    wait_take;
    periph_req <= 12'h0;
    `CHK("idx2", 4'hb, irq_per_index_q)
    `CHK("pvec2", 8'h33, irq_vector_q)
    mask_level_field <= 4'h5;
    periph_req <= 12'h001;
    idle(10);
    `CHK("pmasked", 1'b0, irq_req_q)
    periph_req <= 12'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic summarize;
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, break_req, stall} = 4'h0;
    {reg_addr, reg_wdata, reg_be} = 66'h0;
    nmi_pin = 1'b1;
    level_request_pins_n = 4'hf;
    periph_req = 12'h0;
    mask_level_field = 4'h0;
    vector_base = 32'h0000_1000;
    cs_n_in = 4'h5;
    ext_vec = 8'h0;
    idle(2);
    rst_b <= 1'b1;
    idle(3);
    t_regs;
    t_pins_auto;
    t_pins_ext;
    t_nmi_brk;
    t_periph;
    summarize;
  end
  // Watchdog against a hang
  initial begin
    idle(20000);
    mismatches++;
    summarize;
  end
endmodule // interrupt_priority_controller_tb_top
